//--- microword_pkg.sv
// shared constants and carrier types for the microword field decoder
package microword_pkg;

    // microword geometry
    localparam int MW_W = 48;
    localparam int LEVEL_N = 128;

    // format numbers carried in microword bits 0..2
    localparam logic [2:0] FMT_TEST8 = 3'h0;
    localparam logic [2:0] FMT_LEVEL = 3'h1;
    localparam logic [2:0] FMT_PULSE = 3'h2;
    localparam logic [2:0] FMT_LIT8 = 3'h3;
    localparam logic [2:0] FMT_BRANCH8 = 3'h4;
    localparam logic [2:0] FMT_LIT16 = 3'h5;
    localparam logic [2:0] FMT_BRANCH16 = 3'h6;
    localparam logic [2:0] FMT_ILLEGAL = 3'h7;

    // external data-bus source codes
    localparam logic [4:0] SRC_CPU_UPPER = 5'h02;
    localparam logic [4:0] SRC_CPU_LOWER = 5'h03;
    localparam logic [4:0] SRC_BURST_UPPER = 5'h04;
    localparam logic [4:0] SRC_BURST_LOWER = 5'h05;
    localparam logic [4:0] SRC_NONBURST_UPPER = 5'h06;
    localparam logic [4:0] SRC_NONBURST_LOWER = 5'h07;
    localparam logic [4:0] SRC_QUEUE_DATA = 5'h08;
    localparam logic [4:0] SRC_QUEUE_SWAP = 5'h09;
    localparam logic [4:0] SRC_QUEUE_COUNT = 5'h0A;
    localparam logic [4:0] SRC_READ_DATA = 5'h0B;
    localparam logic [4:0] SRC_SERIAL_SW = 5'h0C;
    localparam logic [4:0] SRC_RATE_SW = 5'h0D;
    localparam logic [4:0] SRC_POLL_REG = 5'h0E;
    localparam logic [4:0] SRC_PROC_DEST0 = 5'h10;
    localparam logic [4:0] SRC_PROC_DEST1 = 5'h11;
    localparam logic [4:0] SRC_RAM_DATA = 5'h12;
    localparam logic [4:0] SRC_RAM_DIRECT = 5'h13;
    localparam logic [4:0] SRC_RAM_SWAP = 5'h14;
    localparam logic [4:0] SRC_RAM_SWAP_DIRECT = 5'h15;
    localparam logic [4:0] SRC_RAM_COUNT = 5'h16;

    // external data-bus destination codes
    localparam logic [4:0] DST_NB_WR_UPPER = 5'h02;
    localparam logic [4:0] DST_NB_WR_LOWER = 5'h03;
    localparam logic [4:0] DST_BYTE_UPPER = 5'h04;
    localparam logic [4:0] DST_BYTE_LOWER = 5'h05;
    localparam logic [4:0] DST_ADDR_UPPER = 5'h08;
    localparam logic [4:0] DST_ADDR_LOWER = 5'h09;
    localparam logic [4:0] DST_CNT_UPPER = 5'h0A;
    localparam logic [4:0] DST_CNT_LOWER = 5'h0B;
    localparam logic [4:0] DST_RAM_DATA = 5'h0C;
    localparam logic [4:0] DST_RAM_DIRECT = 5'h0D;
    localparam logic [4:0] DST_RAM_COUNT = 5'h0E;
    localparam logic [4:0] DST_HALT_UPPER = 5'h10;
    localparam logic [4:0] DST_HALT_LOWER = 5'h11;
    localparam logic [4:0] DST_QUEUE_DATA = 5'h12;
    localparam logic [4:0] DST_QUEUE_SWAP = 5'h13;
    localparam logic [4:0] DST_QUEUE_COUNT = 5'h14;
    localparam logic [4:0] DST_LOAD_DATA = 5'h15;
    localparam logic [4:0] DST_LOAD_CTRL = 5'h16;

    // alu destination code meaning no_destination
    localparam logic [2:0] ALU_DEST_NONE = 3'h1;
    // test number implied by the one-bit test type
    localparam logic [4:0] TEST_HIGH = 5'h10;

    // software port offsets and reset values
    localparam logic [1:0] CTRL_OFS = 2'h0;
    localparam logic [1:0] STATUS_OFS = 2'h1;
    localparam int CTRL_EN_BIT = 0;
    localparam int STATUS_ILLEGAL_BIT = 3;
    localparam logic CTRL_EN_RST = 1'b1;

    typedef struct packed {
        logic [2:0] operands;
        logic [2:0] func;
        logic carry_in;
        logic out_en;
        logic [2:0] dest;
        logic [3:0] a_addr;
        logic [3:0] b_addr;
    } alu_ctrl_t;

    typedef struct packed {
        logic [1:0] jump_type;
        logic polarity;
        logic test_en;
        logic [2:0] test_group;
        logic [4:0] test_num;
        logic uncond;
        logic [15:0] target;
    } seq_ctrl_t;

    typedef struct packed {
        logic cpu_upper, cpu_lower, burst_upper, burst_lower;
        logic nonburst_upper, nonburst_lower;
        logic queue_data, queue_swap, queue_count, read_data;
        logic serial_sw, rate_sw, poll_reg, proc_dest;
        logic ram_data, ram_direct, ram_swap, ram_swap_direct, ram_count;
    } src_sel_t;

    typedef struct packed {
        logic nb_wr_upper, nb_wr_lower, byte_upper, byte_lower;
        logic addr_upper, addr_lower, cnt_upper, cnt_lower;
        logic ram_data, ram_direct, ram_count, halt_upper, halt_lower;
        logic queue_data, queue_swap, queue_count, load_data, load_ctrl;
    } dst_strobe_t;

    typedef struct packed {
        logic [15:0] grp_a;
        logic [15:0] grp_b;
        logic [15:0] grp_c;
        logic [15:0] grp_d;
    } pulse_order_t;

endpackage : microword_pkg

//--- onehot_decode.sv
// one-hot decoder of a binary code with a global enable
`timescale 1ns/1ns
`default_nettype none
module onehot_decode #(
    parameter int IN_W = 4
) (
    input wire logic [IN_W-1:0] code,
    input wire logic en,
    output logic [(2**IN_W)-1:0] hot
);
    // one comparator per output line
    for (genvar i = 0; i < 2**IN_W; i++) begin : g_line
        assign hot[i] = en && (code == IN_W'(i));
    end
endmodule : onehot_decode
`default_nettype wire

//--- microword_field_decoder.sv
// decoder of the 48-bit horizontal microword into engine controls
// Notes on behaviour
// [RL1] bits 0..2, bit 0 MSB, give the format number 0..7
// [RL2] bits 3..7 pick the bus source; bits 4..7 also give register A
// [RL3] bits 8..11, bit 8 MSB, give register B directly
// [RL4] source 2..A: data halves, burst, nonburst, queue data/swap/counter
// [RL5] source B..E reads and switches; 10/11 proc dest; 12..16 scratch paths
// [RL6] bit 12 set disables interrupt handling for this instruction
// [RL7] bits 13..15 choose the alu operand pair
// [RL8] bit 16 drives the alu carry-in
// [RL9] bits 17..19, bit 17 MSB, choose the alu operation
// [RL10] bit 20 enables the alu onto the internal data bus
// [RL11] bits 21..23, bit 23 MSB, choose the alu result destination
// [RL12] destination code is bit 28 over bits 24..27
// [RL13] destination codes strobe writes, address, counter, ram, halt, queue
// [RL14] bits 29..30 choose sequencer jump type
// [RL15] bit 31 zero treats the selected condition as true
// [RL16] format 0: test enable, test number, pulse order, hop address
// [RL17] format 0 issues its pulse order only in group A
// [RL18] formats 1..3: test group and test type, giving test 0 or 16
// [RL19] format 1: bits 37..43 pick one of 128 level orders, bit 36 level
// [RL20] only format 1 ever changes a level order
// [RL21] format 2: bits 36..39 enable groups A..D sharing one 1-of-16 code
// [RL22] format 3: 8-bit literal zero-extended, not a ram address
// [RL23] formats 0..3: four-bit absolute hop address
// [RL24] format 4: test group, test number, absolute 8-bit branch
// [RL25] format 5: 16-bit literal, usable as scratch ram address
// [RL26] format 6: unconditional branch to absolute 16-bit address
// [RL27] format 7 and unused destinations make no strobe, order or load
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module microword_field_decoder (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic mw_valid,
    input wire logic [0:47] microword,
    input wire logic [1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output microword_pkg::alu_ctrl_t alu_ctrl,
    output microword_pkg::seq_ctrl_t seq,
    output microword_pkg::src_sel_t src_sel,
    output microword_pkg::dst_strobe_t dst_strobe,
    output microword_pkg::pulse_order_t pulse,
    output logic [15:0] literal,
    output logic literal_valid,
    output logic literal_ram_ok,
    output logic int_disable,
    output logic [127:0] level_orders
);

    ////////////////////////////////////////////////////////////////////
    // field extraction
    logic [2:0] fmt;
    logic [4:0] src_code;
    logic [4:0] dst_code;
    logic [2:0] alu_dest_raw;
    logic decode_en_reg;
    logic decode_ok;
    logic fmt_is_test3;

    assign fmt = microword[0:2]; // [RL1]
    assign src_code = microword[3:7]; // [RL2]
    assign dst_code = {microword[28], microword[24:27]}; // [RL12]
    // this field is printed with its MSB at the high bit number
    assign alu_dest_raw = {microword[23], microword[22], microword[21]};
    // format 7 and a disabled decoder act as a no-operation
    assign decode_ok = mw_valid && decode_en_reg
        && (fmt != microword_pkg::FMT_ILLEGAL); // [RL27]
    assign fmt_is_test3 = (fmt == microword_pkg::FMT_LEVEL)
        || (fmt == microword_pkg::FMT_PULSE)
        || (fmt == microword_pkg::FMT_LIT8);

    ////////////////////////////////////////////////////////////////////
    // one-hot decodes, shared decoder module
    logic [31:0] src_hot;
    logic [31:0] dst_hot;
    logic [15:0] pulse_hot;
    logic [127:0] level_hot;
    logic fmt0_ok;
    logic fmt2_ok;
    logic fmt1_ok;

    assign fmt0_ok = decode_ok && (fmt == microword_pkg::FMT_TEST8);
    assign fmt1_ok = decode_ok && (fmt == microword_pkg::FMT_LEVEL);
    assign fmt2_ok = decode_ok && (fmt == microword_pkg::FMT_PULSE);

    onehot_decode #(.IN_W(5)) u_src_dec (
        .code(src_code),
        .en(decode_ok),
        .hot(src_hot)
    );
    onehot_decode #(.IN_W(5)) u_dst_dec (
        .code(dst_code),
        .en(decode_ok),
        .hot(dst_hot)
    );
    onehot_decode #(.IN_W(4)) u_pulse_dec (
        .code(microword[40:43]),
        .en(fmt0_ok || fmt2_ok),
        .hot(pulse_hot)
    );
    // level order index, bit 37 MSB, only live in format 1
    onehot_decode #(.IN_W(7)) u_level_dec (
        .code(microword[37:43]),
        .en(fmt1_ok), // [RL20]
        .hot(level_hot) // [RL19]
    );

    ////////////////////////////////////////////////////////////////////
    // bus source selects
    microword_pkg::src_sel_t src_next;
    assign src_next.cpu_upper = src_hot[microword_pkg::SRC_CPU_UPPER]; // [RL4]
    assign src_next.cpu_lower = src_hot[microword_pkg::SRC_CPU_LOWER];
    assign src_next.burst_upper = src_hot[microword_pkg::SRC_BURST_UPPER];
    assign src_next.burst_lower = src_hot[microword_pkg::SRC_BURST_LOWER];
    assign src_next.nonburst_upper = src_hot[microword_pkg::SRC_NONBURST_UPPER];
    assign src_next.nonburst_lower = src_hot[microword_pkg::SRC_NONBURST_LOWER];
    assign src_next.queue_data = src_hot[microword_pkg::SRC_QUEUE_DATA];
    assign src_next.queue_swap = src_hot[microword_pkg::SRC_QUEUE_SWAP];
    assign src_next.queue_count = src_hot[microword_pkg::SRC_QUEUE_COUNT];
    assign src_next.read_data = src_hot[microword_pkg::SRC_READ_DATA]; // [RL5]
    assign src_next.serial_sw = src_hot[microword_pkg::SRC_SERIAL_SW];
    assign src_next.rate_sw = src_hot[microword_pkg::SRC_RATE_SW];
    assign src_next.poll_reg = src_hot[microword_pkg::SRC_POLL_REG];
    // both codes reach the same processor destination register
    assign src_next.proc_dest = src_hot[microword_pkg::SRC_PROC_DEST0]
        || src_hot[microword_pkg::SRC_PROC_DEST1];
    assign src_next.ram_data = src_hot[microword_pkg::SRC_RAM_DATA];
    assign src_next.ram_direct = src_hot[microword_pkg::SRC_RAM_DIRECT];
    assign src_next.ram_swap = src_hot[microword_pkg::SRC_RAM_SWAP];
    assign src_next.ram_swap_direct = src_hot[microword_pkg::SRC_RAM_SWAP_DIRECT];
    assign src_next.ram_count = src_hot[microword_pkg::SRC_RAM_COUNT];

    ////////////////////////////////////////////////////////////////////
    // bus destination strobes; unused codes simply have no line
    microword_pkg::dst_strobe_t dst_next;
    assign dst_next.nb_wr_upper = dst_hot[microword_pkg::DST_NB_WR_UPPER]; // [RL13]
    assign dst_next.nb_wr_lower = dst_hot[microword_pkg::DST_NB_WR_LOWER];
    assign dst_next.byte_upper = dst_hot[microword_pkg::DST_BYTE_UPPER];
    assign dst_next.byte_lower = dst_hot[microword_pkg::DST_BYTE_LOWER];
    assign dst_next.addr_upper = dst_hot[microword_pkg::DST_ADDR_UPPER];
    assign dst_next.addr_lower = dst_hot[microword_pkg::DST_ADDR_LOWER];
    assign dst_next.cnt_upper = dst_hot[microword_pkg::DST_CNT_UPPER];
    assign dst_next.cnt_lower = dst_hot[microword_pkg::DST_CNT_LOWER];
    assign dst_next.ram_data = dst_hot[microword_pkg::DST_RAM_DATA];
    assign dst_next.ram_direct = dst_hot[microword_pkg::DST_RAM_DIRECT];
    assign dst_next.ram_count = dst_hot[microword_pkg::DST_RAM_COUNT];
    assign dst_next.halt_upper = dst_hot[microword_pkg::DST_HALT_UPPER];
    assign dst_next.halt_lower = dst_hot[microword_pkg::DST_HALT_LOWER];
    assign dst_next.queue_data = dst_hot[microword_pkg::DST_QUEUE_DATA];
    assign dst_next.queue_swap = dst_hot[microword_pkg::DST_QUEUE_SWAP];
    assign dst_next.queue_count = dst_hot[microword_pkg::DST_QUEUE_COUNT];
    assign dst_next.load_data = dst_hot[microword_pkg::DST_LOAD_DATA];
    assign dst_next.load_ctrl = dst_hot[microword_pkg::DST_LOAD_CTRL];

    ////////////////////////////////////////////////////////////////////
    // alu controls; a dead instruction must not load any register
    microword_pkg::alu_ctrl_t alu_next;
    assign alu_next.a_addr = microword[4:7]; // [RL2]
    assign alu_next.b_addr = microword[8:11]; // [RL3]
    assign alu_next.operands = microword[13:15]; // [RL7]
    assign alu_next.carry_in = decode_ok && microword[16]; // [RL8]
    assign alu_next.func = microword[17:19]; // [RL9]
    assign alu_next.out_en = decode_ok && microword[20]; // [RL10]
    assign alu_next.dest = decode_ok ? alu_dest_raw
        : microword_pkg::ALU_DEST_NONE; // [RL11] [RL27]

    ////////////////////////////////////////////////////////////////////
    // sequencer controls, target always absolute
    microword_pkg::seq_ctrl_t seq_next;
    logic fmt_has_test5;
    assign fmt_has_test5 = (fmt == microword_pkg::FMT_TEST8)
        || (fmt == microword_pkg::FMT_BRANCH8);
    assign seq_next.jump_type = microword[29:30]; // [RL14]
    assign seq_next.polarity = microword[31]; // [RL15]
    assign seq_next.test_en = decode_ok && (fmt_has_test5 || fmt_is_test3); // [RL16]
    assign seq_next.test_group = microword[32:34];
    // short test field only names test 0 or test 16
    assign seq_next.test_num = fmt_has_test5 ? microword[35:39]
        : (microword[35] ? microword_pkg::TEST_HIGH : 5'h00); // [RL18] [RL24]
    assign seq_next.uncond = decode_ok && (fmt == microword_pkg::FMT_BRANCH16); // [RL26]
    assign seq_next.target = (fmt == microword_pkg::FMT_BRANCH16)
        ? microword[32:47]
        : (fmt == microword_pkg::FMT_BRANCH8) ? {8'h00, microword[40:47]}
        : {12'h000, microword[44:47]}; // [RL23]

    ////////////////////////////////////////////////////////////////////
    // literals and orders
    logic [15:0] literal_next;
    logic literal_valid_next;
    logic literal_ram_ok_next;
    microword_pkg::pulse_order_t pulse_next;
    logic [127:0] level_next;

    assign literal_next = (fmt == microword_pkg::FMT_LIT16) ? microword[32:47]
        : (fmt == microword_pkg::FMT_LIT8) ? {8'h00, microword[36:43]}
        : 16'h0000; // [RL22] [RL25]
    assign literal_valid_next = decode_ok && ((fmt == microword_pkg::FMT_LIT16)
        || (fmt == microword_pkg::FMT_LIT8));
    // the short literal is too narrow to serve as a ram address
    assign literal_ram_ok_next = decode_ok && (fmt == microword_pkg::FMT_LIT16); // [RL25]
    assign pulse_next.grp_a = (fmt0_ok || (fmt2_ok && microword[36]))
        ? pulse_hot : 16'h0000; // [RL17] [RL21]
    assign pulse_next.grp_b = (fmt2_ok && microword[37]) ? pulse_hot : 16'h0000;
    assign pulse_next.grp_c = (fmt2_ok && microword[38]) ? pulse_hot : 16'h0000;
    assign pulse_next.grp_d = (fmt2_ok && microword[39]) ? pulse_hot : 16'h0000;
    // level orders hold their value until a format 1 word touches them
    assign level_next = microword[36] ? (level_orders | level_hot)
        : (level_orders & ~level_hot); // [RL19] [RL20]

    ////////////////////////////////////////////////////////////////////
    // software port: control and status
    logic wr_ctrl;
    logic wr_status;
    logic illegal_reg;
    logic illegal_next;
    logic [2:0] last_fmt_reg;
    logic [31:0] rdata_next;

    assign wr_ctrl = reg_wr && (reg_addr == microword_pkg::CTRL_OFS);
    assign wr_status = reg_wr && (reg_addr == microword_pkg::STATUS_OFS);
    // a new illegal word beats a clear in the same cycle
    assign illegal_next = (mw_valid && (fmt == microword_pkg::FMT_ILLEGAL))
        || (illegal_reg && !(wr_status
        && reg_wdata[microword_pkg::STATUS_ILLEGAL_BIT]));
    assign rdata_next = !reg_rd ? 32'h0000_0000
        : (reg_addr == microword_pkg::CTRL_OFS) ? {31'h0, decode_en_reg}
        : (reg_addr == microword_pkg::STATUS_OFS)
            ? {28'h0, illegal_reg, last_fmt_reg}
        : 32'h0000_0000;

    // control and status flops
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            decode_en_reg <= microword_pkg::CTRL_EN_RST;
            illegal_reg <= 1'b0;
            last_fmt_reg <= 3'h0;
            reg_rdata <= 32'h0000_0000;
        end else begin
            if (wr_ctrl) begin
                decode_en_reg <= reg_wdata[microword_pkg::CTRL_EN_BIT];
            end
            if (mw_valid) begin
                last_fmt_reg <= fmt;
            end
            illegal_reg <= illegal_next;
            reg_rdata <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // registered decode outputs, one cycle after the word
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            alu_ctrl <= '{dest: microword_pkg::ALU_DEST_NONE, default: '0};
            seq <= '0;
            src_sel <= '0;
            dst_strobe <= '0;
            pulse <= '0;
            literal <= 16'h0000;
            literal_valid <= 1'b0;
            literal_ram_ok <= 1'b0;
            int_disable <= 1'b0;
            level_orders <= 128'h0;
        end else begin
            alu_ctrl <= alu_next;
            seq <= seq_next;
            src_sel <= src_next;
            dst_strobe <= dst_next;
            pulse <= pulse_next;
            literal <= literal_next;
            literal_valid <= literal_valid_next;
            literal_ram_ok <= literal_ram_ok_next;
            int_disable <= decode_ok && microword[12]; // [RL6]
            level_orders <= level_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    carry_follows_a: assert property (decode_ok |=> // [RL8]
        alu_ctrl.carry_in == $past(microword[16]))
        else $error("carry-in does not follow bit 16");
    int_disable_a: assert property (decode_ok && microword[12] |=> // [RL6]
        int_disable)
        else $error("interrupt disable missing");
    fmt7_quiet_a: assert property (mw_valid && fmt == 3'h7 |=> // [RL27]
        dst_strobe == '0 && pulse == '0 && !alu_ctrl.out_en
        && alu_ctrl.dest == microword_pkg::ALU_DEST_NONE
        && $stable(level_orders))
        else $error("format 7 produced an action");
    level_hold_a: assert property (!fmt1_ok |=> $stable(level_orders)) // [RL20]
        else $error("level order changed outside format 1");
    level_set_a: assert property (fmt1_ok |=> // [RL19]
        level_orders[$past(microword[37:43])] == $past(microword[36]))
        else $error("level order not set as commanded");
    fmt0_group_a: assert property (fmt0_ok |=> // [RL17]
        pulse.grp_b == 16'h0 && pulse.grp_c == 16'h0 && pulse.grp_d == 16'h0
        && pulse.grp_a == (16'h1 << $past(microword[40:43])))
        else $error("format 0 pulse outside group A");
    lit8_zero_a: assert property (decode_ok && fmt == 3'h3 |=> // [RL22]
        literal[15:8] == 8'h00 && literal_valid && !literal_ram_ok)
        else $error("short literal mis-extended");
    branch16_a: assert property (decode_ok && fmt == 3'h6 |=> // [RL26]
        seq.uncond && seq.target == $past(microword[32:47]) && !seq.test_en)
        else $error("16-bit branch wrong");
    test_type_a: assert property (decode_ok && fmt_is_test3 |=> // [RL18]
        seq.test_num == ($past(microword[35]) ? 5'h10 : 5'h00))
        else $error("short test number wrong");
    dst_ctrl_a: assert property (decode_ok && dst_code == 5'h16 |=> // [RL13]
        dst_strobe.load_ctrl ##1 (!dst_strobe.load_ctrl
        || $past(decode_ok && dst_code == 5'h16)))
        else $error("load control strobe wrong");

    cov_level_set: cover property (fmt1_ok && microword[36]);
    cov_all_groups: cover property (fmt2_ok && microword[36:39] == 4'hF);
    cov_branch16: cover property (decode_ok && fmt == 3'h6);
    cov_illegal: cover property (mw_valid && fmt == 3'h7);

endmodule : microword_field_decoder
`default_nettype wire

//--- order_sink_model.sv
// far-side model of the order decoders, counting every pulse order fired
`timescale 1ns/1ns
`default_nettype none
module order_sink_model (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire microword_pkg::pulse_order_t pulse,
    output logic [7:0] pulse_cnt
);
    // every high line is one order; a stuck line would inflate the total
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pulse_cnt <= 8'h00;
        end else begin
            pulse_cnt <= pulse_cnt + 8'($countones(pulse));
        end
    end
endmodule : order_sink_model
`default_nettype wire

//--- microword_field_decoder_tb.sv
// self-checking testbench of the microword field decoder
`timescale 1ns/1ns
`default_nettype none
module microword_field_decoder_tb;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic mw_valid = 1'b0;
    logic [0:47] microword = 48'h0;
    logic [1:0] reg_addr = 2'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    microword_pkg::alu_ctrl_t alu_ctrl;
    microword_pkg::seq_ctrl_t seq;
    microword_pkg::src_sel_t src_sel;
    microword_pkg::dst_strobe_t dst_strobe;
    microword_pkg::pulse_order_t pulse;
    microword_pkg::src_sel_t es;
    microword_pkg::dst_strobe_t ed;
    logic [15:0] literal;
    logic literal_valid, literal_ram_ok, int_disable;
    logic [127:0] level_orders;
    logic [7:0] pulse_cnt;
    int n_errors = 0;
    int compares = 0;
    int cyc = 0;
    // bits 3..31: queue source, reg b B, int off, ops 5, carry, func 6,
    // out enable, alu dest 4, bus dest 12, push-and-branch, polarity 0
    localparam logic [28:0] CMN = {5'h08, 4'hB, 1'b1, 3'h5, 1'b1, 3'h6,
        1'b1, 3'b001, 4'h2, 1'b1, 2'h2, 1'b0};

    microword_field_decoder dut_u (.ref_clk(ref_clk), .arst_n(arst_n),
        .mw_valid(mw_valid), .microword(microword), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .alu_ctrl(alu_ctrl), .seq(seq),
        .src_sel(src_sel), .dst_strobe(dst_strobe), .pulse(pulse),
        .literal(literal), .literal_valid(literal_valid),
        .literal_ram_ok(literal_ram_ok), .int_disable(int_disable),
        .level_orders(level_orders));
    order_sink_model sink_u (.ref_clk(ref_clk), .arst_n(arst_n),
        .pulse(pulse), .pulse_cnt(pulse_cnt));

    ////////////////////////////////////////////////////////////////////////
    always #10 ref_clk = ~ref_clk;

    // hang guard: the whole run needs well under 200 cycles
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_errors = n_errors + 1;
            give_verdict();
        end
    end

    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one word in, outputs sampled after the edge that decodes it
    task automatic send(input logic [2:0] f, input logic [28:0] c,
        input logic [15:0] up);
        @(posedge ref_clk);
        mw_valid <= 1'b1;
        microword <= {f, c, up};
        @(posedge ref_clk);
        mw_valid <= 1'b0;
        #1;
    endtask : send

    task automatic reg_access(input logic wr, input logic [1:0] a,
        input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= wr;
        reg_rd <= !wr;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
    endtask : reg_access

    task automatic give_verdict();
        $display("errors=%0d compares=%0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge ref_clk);
        arst_n <= 1'b1;
        reg_access(1'b0, 2'h0, 32'h0);
        chk(reg_rdata, 32'h1);
        reg_access(1'b1, 2'h2, 32'hF);
        reg_access(1'b0, 2'h2, 32'h0);
        chk(reg_rdata, 32'h0);
        send(3'h5, CMN, 16'hA5C3);
        es = '0;
        es.queue_data = 1'b1;
        ed = '0;
        ed.queue_data = 1'b1;
        chk(src_sel, es);
        chk({alu_ctrl.a_addr, alu_ctrl.b_addr}, 8'h8B);
        chk(int_disable, 1'b1);
        chk({alu_ctrl.operands, alu_ctrl.carry_in}, 4'hB);
        chk({alu_ctrl.func, alu_ctrl.out_en}, 4'hD);
        chk(alu_ctrl.dest, 3'h4);
        chk(dst_strobe, ed);
        chk({seq.jump_type, seq.polarity}, 3'h4);
        chk({literal, literal_valid, literal_ram_ok}, 18'h2970F);
        send(3'h1, 29'h0, {3'h2, 1'b1, 1'b1, 7'h05, 4'h9});
        chk(level_orders, 128'h20);
        chk({seq.test_group, seq.test_num}, 8'h50);
        chk(seq.target, 16'h0009);
        send(3'h0, 29'h0, {3'h1, 5'h13, 4'h7, 4'hC});
        chk(pulse, 64'h0080_0000_0000_0000);
        chk({seq.test_en, seq.test_num, seq.target}, 22'h33000C);
        chk(level_orders, 128'h20);
        send(3'h2, 29'h0, {4'h0, 4'hF, 4'h3, 4'h0});
        chk(pulse, {4{16'h0008}});
        send(3'h2, 29'h0, {4'h0, 4'h5, 4'hF, 4'h0});
        chk(pulse, {16'h0, 16'h8000, 16'h0, 16'h8000});
        send(3'h3, 29'h0, {4'h0, 8'hE7, 4'h0});
        chk({literal, literal_valid, literal_ram_ok}, 18'h0039E);
        chk(pulse_cnt, 8'h07);
        send(3'h4, 29'h0, {3'h3, 5'h0A, 8'hD4});
        chk({seq.test_num, seq.target}, 21'h0A00D4);
        // scratch counter source and scratch data destination ride along
        send(3'h6, {5'h16, 16'h0, 4'hC, 1'b0, 3'h0}, 16'hBEEF);
        chk({seq.uncond, seq.target}, 17'h1BEEF);
        es = '0;
        es.ram_count = 1'b1;
        ed = '0;
        ed.ram_data = 1'b1;
        chk(src_sel, es);
        chk(dst_strobe, ed);
        // source F and destination F have no line at all
        send(3'h1, {5'h0F, 16'h0, 4'hF, 1'b0, 3'h0},
            {4'h0, 1'b0, 7'h05, 4'h0});
        chk(level_orders, 128'h0);
        chk({dst_strobe, src_sel}, 37'h0);
        send(3'h7, CMN, 16'hFFFF);
        chk({dst_strobe, src_sel, pulse}, 101'h0);
        chk({literal_valid, literal_ram_ok, int_disable, seq.test_en,
            seq.uncond, alu_ctrl.out_en, alu_ctrl.carry_in}, 7'h0);
        chk(alu_ctrl.dest, microword_pkg::ALU_DEST_NONE);
        reg_access(1'b0, 2'h1, 32'h0);
        chk(reg_rdata, 32'hF);
        reg_access(1'b1, 2'h1, 32'h8);
        reg_access(1'b0, 2'h1, 32'h0);
        chk(reg_rdata, 32'h7);
        // a disabled decoder must treat every word as a no-operation
        reg_access(1'b1, 2'h0, 32'h0);
        send(3'h0, CMN, 16'h0070);
        chk({dst_strobe, src_sel, pulse, int_disable}, 102'h0);
        chk(alu_ctrl.dest, microword_pkg::ALU_DEST_NONE);
        reg_access(1'b0, 2'h0, 32'h0);
        chk(reg_rdata, 32'h0);
        give_verdict();
    end
endmodule : microword_field_decoder_tb
`default_nettype wire
